// >>> common/asr_pkg.sv
// constants, register map and types of the async serial receiver
package asr_pkg;
   // -----------------------------------------------------------------
   // register offsets
   // -----------------------------------------------------------------
   localparam logic [3:0] OFF_RCV_STAT_CTRL = 4'h0;
   localparam logic [3:0] OFF_TX_STAT_CTRL = 4'h1;
   localparam logic [3:0] OFF_BAUD_CTRL = 4'h2;
   localparam logic [3:0] OFF_DIV_LOW = 4'h3;
   localparam logic [3:0] OFF_DIV_HIGH = 4'h4;
   localparam logic [3:0] OFF_RX_DATA = 4'h5;
   localparam logic [3:0] OFF_INT_CTRL = 4'h6;
   localparam logic [3:0] OFF_PER_ENABLE = 4'h7;
   localparam logic [3:0] OFF_PER_FLAG = 4'h8;
   // -----------------------------------------------------------------
   // field positions
   // -----------------------------------------------------------------
   localparam int RCS_PORT_EN = 7;
   localparam int RCS_NINE = 6;
   localparam int RCS_RX_EN = 4;
   localparam int RCS_ADDR_DET = 3;
   localparam int RCS_FRAME = 2;
   localparam int RCS_OVERRUN = 1;
   localparam int RCS_BIT9 = 0;
   localparam int TXS_SYNC = 4;
   localparam int TXS_HIGH_SPEED = 2;
   localparam int TXS_SHIFT_EMPTY = 1;
   localparam int BDC_RX_IDLE = 6;
   localparam int BDC_WIDE = 3;
   localparam int INT_GLOBAL = 7;
   localparam int INT_PERIPH = 6;
   localparam int PIE_RX = 5;
   localparam int PIR_RX = 5;
   // -----------------------------------------------------------------
   // write masks and reset values
   // -----------------------------------------------------------------
   localparam logic [7:0] RCS_WR_MASK = 8'hf8;
   localparam logic [7:0] TXS_WR_MASK = 8'hfd;
   localparam logic [7:0] BDC_WR_MASK = 8'h1b;
   localparam logic [7:0] INT_WR_MASK = 8'hc0;
   localparam logic [7:0] PIE_WR_MASK = 8'h20;
   localparam logic [7:0] REG_RESET = 8'h00;
   // -----------------------------------------------------------------
   // bit timing
   // -----------------------------------------------------------------
   localparam logic [3:0] SAMPLE_A = 4'h7;
   localparam logic [3:0] SAMPLE_B = 4'h8;
   localparam logic [3:0] SAMPLE_C = 4'h9;
   localparam logic [3:0] TICK_STEP = 4'h1;
   localparam logic [3:0] BITS_EIGHT = 4'h8;
   localparam logic [3:0] BITS_NINE = 4'h9;
   // -----------------------------------------------------------------
   // receive buffer
   // -----------------------------------------------------------------
   localparam int ENTRY_W = 10;
   localparam int ENT_FRAMING_ERROR = 9;
   localparam int ENT_BIT9 = 8;
   localparam logic [1:0] FIFO_FULL = 2'h2;
   localparam logic [1:0] FIFO_EMPTY = 2'h0;
   localparam logic [1:0] FIFO_STEP = 2'h1;
   // -----------------------------------------------------------------
   // receiver states
   // -----------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_START = 4'h2,
      ST_DATA = 4'h4,
      ST_STOP = 4'h8
   } asr_state_type;
endpackage

// >>> verilog/asr_fifo.sv
// two-entry receive buffer with registered head entry
`timescale 1ns/1ps
module asr_fifo (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic clear_in,
   input wire logic push_in,
   input wire logic [asr_pkg::ENTRY_W-1:0] push_data_in,
   input wire logic pop_in,
   output logic [asr_pkg::ENTRY_W-1:0] head_out,
   output logic [1:0] count_out
);
   logic [asr_pkg::ENTRY_W-1:0] ent_q [2];
   logic [asr_pkg::ENTRY_W-1:0] ent_d [2];
   logic [1:0] cnt_q;
   logic [1:0] cnt_d;
   logic do_pop;
   logic do_push;
   logic [1:0] slot;

   always_comb begin
      ent_d = ent_q;
      cnt_d = cnt_q;
      slot = cnt_q;
      do_pop = pop_in && (cnt_q != asr_pkg::FIFO_EMPTY);
      do_push = push_in && ((cnt_q != asr_pkg::FIFO_FULL) || do_pop);
      if (clear_in) begin
         cnt_d = asr_pkg::FIFO_EMPTY;
      end else begin
         if (do_pop) begin
            ent_d[0] = ent_q[1];
            slot = cnt_q - asr_pkg::FIFO_STEP;
         end
         if (do_push) begin
            ent_d[slot[0]] = push_data_in;
         end
         cnt_d = slot + (do_push ? asr_pkg::FIFO_STEP : asr_pkg::FIFO_EMPTY);
      end
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         ent_q[0] <= '0;
         ent_q[1] <= '0;
         cnt_q <= asr_pkg::FIFO_EMPTY;
      end else begin
         ent_q <= ent_d;
         cnt_q <= cnt_d;
      end
   end

   assign head_out = ent_q[0];
   assign count_out = cnt_q;
endmodule

// >>> verilog/asr_receiver.sv
// async serial receiver: line recovery, character framing and registers
//
// Operation
// - oversample line at sixteen ticks per bit
// - finished character goes straight into two-entry buffer
// - receive only with receive, port enabled, async
// - falling edge in idle starts a character
// - false start at half bit aborts silently
// - each data bit decided at its centre
// - low stop sample marks framing error
// - push after stop; data read pops oldest
// - pending flag means enabled with unread data
// - interrupt needs all three enables set
// - framing error stored per entry, shows oldest
// - framing error read-only, cleared by port disable
// - third character while full sets overrun, blocks
// - overrun cleared only by receive/port disable
// - nine-bit mode keeps ninth bit per entry
// - address detect in nine-bit mode keeps only ninth-bit-set characters
// - least significant bit arrives first
// - timing from shared baud generator tick
//
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module asr_receiver (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic [3:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [7:0] reg_rdata_out,
   input wire logic os_tick_in,
   input wire logic rx_line_in,
   output logic [15:0] baud_div_out,
   output logic high_speed_baud_out,
   output logic wide_baud_divider_out,
   output logic pending_out,
   output logic irq_out
);
   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   function automatic logic reg_hit(input logic [3:0] addr,
                                    input logic [3:0] off);
      reg_hit = (addr == off);
   endfunction
   function automatic logic vote3(input logic a, input logic b,
                                  input logic c);
      vote3 = (a & b) | (a & c) | (b & c);
   endfunction

   // -----------------------------------------------------------------
   // declarations
   // -----------------------------------------------------------------
   logic [7:0] rcs_q, rcs_d, txs_q, txs_d, bdc_q, bdc_d;
   logic [7:0] div_lo_q, div_lo_d, div_hi_q, div_hi_d;
   logic [7:0] int_q, int_d, pie_q, pie_d;
   logic [7:0] rdata_q, rdata_d, rcs_view;
   logic sync1_q, sync2_q, sync3_q, line_q, line_d, line_prev_q;
   asr_pkg::asr_state_type state_q, state_d;
   logic [3:0] cnt_q, cnt_d, bits_q, bits_d, nbits;
   logic [8:0] rsr_q, rsr_d, char9;
   logic [1:0] samp_q, samp_d, fifo_cnt;
   logic port_enable, receive_enable, rx9, address_detect_enable, sync_mode, rx_en, overrun_error_q, overrun_error_d, fifo_any;
   logic fall, vote, decide, keep, push, ovr_set, pop, framing_error_vis, bit9_vis;
   logic [asr_pkg::ENTRY_W-1:0] entry, head;

   // -----------------------------------------------------------------
   // control decode
   // -----------------------------------------------------------------
   assign port_enable = rcs_q[asr_pkg::RCS_PORT_EN];
   assign receive_enable = rcs_q[asr_pkg::RCS_RX_EN];
   assign rx9 = rcs_q[asr_pkg::RCS_NINE];
   assign address_detect_enable = rcs_q[asr_pkg::RCS_ADDR_DET];
   assign sync_mode = txs_q[asr_pkg::TXS_SYNC];
   assign rx_en = port_enable && receive_enable && !sync_mode;
   assign nbits = rx9 ? asr_pkg::BITS_NINE : asr_pkg::BITS_EIGHT;

   // -----------------------------------------------------------------
   // line synchroniser
   // -----------------------------------------------------------------
   always_comb begin
      line_d = line_q;
      if (sync2_q == sync3_q) begin
         line_d = sync3_q;
      end
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         sync1_q <= 1'h1;
         sync2_q <= 1'h1;
         sync3_q <= 1'h1;
         line_q <= 1'h1;
         line_prev_q <= 1'h1;
      end else begin
         sync1_q <= rx_line_in;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         line_q <= line_d;
         line_prev_q <= line_q;
      end
   end

   assign fall = line_prev_q && !line_q;

   // -----------------------------------------------------------------
   // character recovery
   // -----------------------------------------------------------------
   assign decide = os_tick_in && (cnt_q == asr_pkg::SAMPLE_C);
   assign vote = vote3(samp_q[0], samp_q[1], line_q);
   assign char9 = rx9 ? rsr_q : {1'h0, rsr_q[8:1]};
   assign entry = {!vote, char9};
   assign keep = !(rx9 && address_detect_enable && !char9[asr_pkg::ENT_BIT9]);

   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      bits_d = bits_q;
      rsr_d = rsr_q;
      samp_d = samp_q;
      push = 1'h0;
      ovr_set = 1'h0;
      if (!rx_en) begin
         state_d = asr_pkg::ST_IDLE;
         cnt_d = '0;
         bits_d = '0;
      end else begin
         unique case (state_q)
            asr_pkg::ST_IDLE: begin
               if (fall && !overrun_error_q) begin
                  state_d = asr_pkg::ST_START;
                  cnt_d = '0;
                  bits_d = '0;
               end
            end
            asr_pkg::ST_START, asr_pkg::ST_DATA, asr_pkg::ST_STOP: begin
               if (os_tick_in) begin
                  cnt_d = cnt_q + asr_pkg::TICK_STEP;
                  if (cnt_q == asr_pkg::SAMPLE_A) begin
                     samp_d[0] = line_q;
                  end
                  if (cnt_q == asr_pkg::SAMPLE_B) begin
                     samp_d[1] = line_q;
                  end
               end
               if (decide) begin
                  if (state_q == asr_pkg::ST_START) begin
                     state_d = vote ? asr_pkg::ST_IDLE
                                    : asr_pkg::ST_DATA;
                  end else if (state_q == asr_pkg::ST_DATA) begin
                     rsr_d = {vote, rsr_q[8:1]};
                     bits_d = bits_q + asr_pkg::TICK_STEP;
                     if (bits_d == nbits) begin
                        state_d = asr_pkg::ST_STOP;
                     end
                  end else begin
                     state_d = asr_pkg::ST_IDLE;
                     if (keep) begin
                        if (fifo_cnt == asr_pkg::FIFO_FULL && !pop) begin
                           ovr_set = 1'h1;
                        end else begin
                           push = 1'h1;
                        end
                     end
                  end
               end
            end
            default: state_d = asr_pkg::ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_q <= asr_pkg::ST_IDLE;
         cnt_q <= '0;
         bits_q <= '0;
         rsr_q <= '0;
         samp_q <= '0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         bits_q <= bits_d;
         rsr_q <= rsr_d;
         samp_q <= samp_d;
      end
   end

   // -----------------------------------------------------------------
   // receive buffer
   // -----------------------------------------------------------------
   assign pop = reg_rd_in && reg_hit(reg_addr_in, asr_pkg::OFF_RX_DATA)
                && (fifo_cnt != asr_pkg::FIFO_EMPTY);

   asr_fifo u_fifo (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .clear_in(!port_enable),
      .push_in(push),
      .push_data_in(entry),
      .pop_in(pop),
      .head_out(head),
      .count_out(fifo_cnt)
   );

   assign fifo_any = (fifo_cnt != asr_pkg::FIFO_EMPTY);
   assign framing_error_vis = fifo_any && head[asr_pkg::ENT_FRAMING_ERROR];
   assign bit9_vis = fifo_any && head[asr_pkg::ENT_BIT9];

   // -----------------------------------------------------------------
   // registers
   // -----------------------------------------------------------------
   always_comb begin
      rcs_d = rcs_q;
      txs_d = txs_q;
      bdc_d = bdc_q;
      div_lo_d = div_lo_q;
      div_hi_d = div_hi_q;
      int_d = int_q;
      pie_d = pie_q;
      if (reg_wr_in) begin
         unique case (reg_addr_in)
            asr_pkg::OFF_RCV_STAT_CTRL:
               rcs_d = reg_wdata_in & asr_pkg::RCS_WR_MASK;
            asr_pkg::OFF_TX_STAT_CTRL:
               txs_d = reg_wdata_in & asr_pkg::TXS_WR_MASK;
            asr_pkg::OFF_BAUD_CTRL:
               bdc_d = reg_wdata_in & asr_pkg::BDC_WR_MASK;
            asr_pkg::OFF_DIV_LOW: div_lo_d = reg_wdata_in;
            asr_pkg::OFF_DIV_HIGH: div_hi_d = reg_wdata_in;
            asr_pkg::OFF_INT_CTRL:
               int_d = reg_wdata_in & asr_pkg::INT_WR_MASK;
            asr_pkg::OFF_PER_ENABLE:
               pie_d = reg_wdata_in & asr_pkg::PIE_WR_MASK;
            default: rcs_d = rcs_q;
         endcase
      end
      // set wins over a clearing write in the same cycle
      if (!port_enable) begin
         overrun_error_d = 1'h0;
      end else if (ovr_set) begin
         overrun_error_d = 1'h1;
      end else if (!receive_enable) begin
         overrun_error_d = 1'h0;
      end else begin
         overrun_error_d = overrun_error_q;
      end
   end

   always_comb begin
      rcs_view = rcs_q;
      rcs_view[asr_pkg::RCS_FRAME] = framing_error_vis;
      rcs_view[asr_pkg::RCS_OVERRUN] = overrun_error_q;
      rcs_view[asr_pkg::RCS_BIT9] = bit9_vis;
      rdata_d = asr_pkg::REG_RESET;
      if (reg_rd_in) begin
         unique case (reg_addr_in)
            asr_pkg::OFF_RCV_STAT_CTRL: rdata_d = rcs_view;
            asr_pkg::OFF_TX_STAT_CTRL: begin
               rdata_d = txs_q;
               rdata_d[asr_pkg::TXS_SHIFT_EMPTY] = 1'h1;
            end
            asr_pkg::OFF_BAUD_CTRL: begin
               rdata_d = bdc_q;
               rdata_d[asr_pkg::BDC_RX_IDLE] = state_q == asr_pkg::ST_IDLE;
            end
            asr_pkg::OFF_DIV_LOW: rdata_d = div_lo_q;
            asr_pkg::OFF_DIV_HIGH: rdata_d = div_hi_q;
            asr_pkg::OFF_RX_DATA: begin
               if (fifo_cnt != asr_pkg::FIFO_EMPTY) begin
                  rdata_d = head[7:0];
               end
            end
            asr_pkg::OFF_INT_CTRL: rdata_d = int_q;
            asr_pkg::OFF_PER_ENABLE: rdata_d = pie_q;
            asr_pkg::OFF_PER_FLAG: begin
               rdata_d[asr_pkg::PIR_RX] = pending_out;
            end
            default: rdata_d = asr_pkg::REG_RESET;
         endcase
      end
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         rcs_q <= asr_pkg::REG_RESET;
         txs_q <= asr_pkg::REG_RESET;
         bdc_q <= asr_pkg::REG_RESET;
         div_lo_q <= asr_pkg::REG_RESET;
         div_hi_q <= asr_pkg::REG_RESET;
         int_q <= asr_pkg::REG_RESET;
         pie_q <= asr_pkg::REG_RESET;
         overrun_error_q <= 1'h0;
         rdata_q <= asr_pkg::REG_RESET;
      end else begin
         rcs_q <= rcs_d;
         txs_q <= txs_d;
         bdc_q <= bdc_d;
         div_lo_q <= div_lo_d;
         div_hi_q <= div_hi_d;
         int_q <= int_d;
         pie_q <= pie_d;
         overrun_error_q <= overrun_error_d;
         rdata_q <= rdata_d;
      end
   end

   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   assign reg_rdata_out = rdata_q;
   assign baud_div_out = {div_hi_q, div_lo_q};
   assign high_speed_baud_out = txs_q[asr_pkg::TXS_HIGH_SPEED];
   assign wide_baud_divider_out = bdc_q[asr_pkg::BDC_WIDE];
   assign pending_out = rx_en && (fifo_cnt != asr_pkg::FIFO_EMPTY);
   assign irq_out = pending_out && pie_q[asr_pkg::PIE_RX]
                    && int_q[asr_pkg::INT_PERIPH]
                    && int_q[asr_pkg::INT_GLOBAL];

   // -----------------------------------------------------------------
   // assertions
   // -----------------------------------------------------------------
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (rst_in);

   sequence s_fall;
      state_q == asr_pkg::ST_IDLE && rx_en && !overrun_error_q && fall;
   endsequence
   sequence s_false_start;
      state_q == asr_pkg::ST_START && rx_en && decide && vote;
   endsequence
   a_start_edge: assert property (s_fall |=>
      state_q == asr_pkg::ST_START && cnt_q == '0)
      else $error("falling edge did not start a character");
   a_start_abort: assert property (s_false_start |=>
      state_q == asr_pkg::ST_IDLE && !$rose(overrun_error_q))
      else $error("false start not abandoned silently");
   a_disabled_idle: assert property (!rx_en |=>
      state_q == asr_pkg::ST_IDLE)
      else $error("receiver active while disabled");
   a_pop_data: assert property (pop |=>
      reg_rdata_out == $past(head[7:0]))
      else $error("data read did not return oldest entry");
   a_push_pending: assert property (push && rx_en |=>
      pending_out || !rx_en)
      else $error("pending flag missing after push");
   a_irq_gate: assert property (irq_out |->
      pending_out && pie_q[asr_pkg::PIE_RX] && int_q[asr_pkg::INT_PERIPH]
      && int_q[asr_pkg::INT_GLOBAL])
      else $error("interrupt without all enables");
   a_port_clear: assert property (!port_enable |=>
      fifo_cnt == asr_pkg::FIFO_EMPTY && !overrun_error_q)
      else $error("port disable did not reset status");
   a_overrun_block: assert property (overrun_error_q |-> !push)
      else $error("character accepted during overrun");
   a_overrun_hold: assert property (overrun_error_q && port_enable && receive_enable |=> overrun_error_q)
      else $error("overrun cleared without disable");
   a_addr_filter: assert property (push && rx9 && address_detect_enable |->
      entry[asr_pkg::ENT_BIT9])
      else $error("data character kept under address detect");
   a_bit_count: assert property ($rose(state_q == asr_pkg::ST_STOP)
      |-> $past(bits_d) == nbits)
      else $error("wrong number of data bits");
endmodule

// >>> test/asr_tx_model.sv
// remote serial transmitter model driving the receive line
`timescale 1ns/1ps
module asr_tx_model (
   input wire logic core_clk_in,
   input wire logic os_tick_in,
   output logic line_out
);
   // ----------------------------------------------
   // line driver, idles at mark
   // ----------------------------------------------
   initial begin
      line_out = 1'b1;
   end
   // bit timing from the shared baud tick
   task automatic ticks(input int n);
      repeat (n) @(posedge core_clk_in iff os_tick_in);
   endtask
   // start, data, stop; a low stop bit gives a bad frame
   task automatic send(input logic [8:0] d, input int nb,
                       input logic stop);
      line_out <= 1'b0;
      ticks(16);
      for (int i = 0; i < nb; i++) begin
         line_out <= d[i];
         ticks(16);
      end
      line_out <= stop;
      ticks(16);
      line_out <= 1'b1;
      ticks(1);
   endtask
   // short low pulse that is gone by the start check
   task automatic glitch();
      line_out <= 1'b0;
      ticks(4);
      line_out <= 1'b1;
      ticks(32);
   endtask
endmodule

// >>> test/asr_receiver_tb_top.sv
// self-checking bench of the async serial receiver
`timescale 1ns/1ps
module asr_receiver_tb_top;
   logic clk, rst, wr, rd, line, hs, wide, pend, irq;
   logic tick = 1'b0;
   logic [3:0] addr;
   logic [7:0] wdata, rdata;
   logic [15:0] div;
   logic [1:0] tcnt = 2'h0;
   logic [3:0] ra [8];
   int error_cnt, compares;
   asr_receiver i_dut (.core_clk_in(clk), .rst_in(rst),
      .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
      .reg_rd_in(rd), .reg_rdata_out(rdata), .os_tick_in(tick),
      .rx_line_in(line), .baud_div_out(div),
      .high_speed_baud_out(hs), .wide_baud_divider_out(wide),
      .pending_out(pend), .irq_out(irq));
   asr_tx_model i_tx (.core_clk_in(clk), .os_tick_in(tick),
      .line_out(line));
   // ----------------------------------------------
   // clock and 16x tick, one tick every 4 cycles
   // ----------------------------------------------
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      tcnt <= tcnt + 2'h1;
      tick <= (tcnt == 2'h3);
   end
   // ----------------------------------------------
   // tasks
   // ----------------------------------------------
   task automatic chk(input string n, input logic [15:0] s,
                      input logic [15:0] e);
      compares++;
      if (s !== e) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wrr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask
   task automatic rdc(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk($sformatf("reg %h", a), {8'h00, rdata}, {8'h00, e});
   endtask
   task automatic wrap_up();
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // ----------------------------------------------
   // watchdog
   // ----------------------------------------------
   initial begin
      repeat (40000) @(posedge clk);
      error_cnt++;
      wrap_up();
   end
   // ----------------------------------------------
   // tests
   // ----------------------------------------------
   initial begin
      {wr, rd, addr, wdata} = '0;
      rst = 1'b1;
      ra = '{4'h0, 4'h1, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8};
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      wrr(4'hf, 8'hff);
      rdc(4'hf, 8'h00);
      foreach (ra[i]) begin
         rdc(ra[i], (ra[i] == asr_pkg::OFF_TX_STAT_CTRL) ?
             8'h02 : asr_pkg::REG_RESET);
      end
      wrr(asr_pkg::OFF_DIV_LOW, 8'h34);
      wrr(asr_pkg::OFF_DIV_HIGH, 8'h12);
      wrr(asr_pkg::OFF_BAUD_CTRL, 8'h08);
      rdc(asr_pkg::OFF_BAUD_CTRL, 8'h48);
      wrr(asr_pkg::OFF_TX_STAT_CTRL, 8'h14);
      chk("baud", {div[15:2], hs, wide}, 16'h1237);
      chk("div", div, 16'h1234);
      wrr(asr_pkg::OFF_RCV_STAT_CTRL, 8'h97);
      rdc(asr_pkg::OFF_RCV_STAT_CTRL, 8'h90);
      i_tx.send(9'h0a5, 8, 1'b1);
      chk("sync pend", pend, 1'b0);
      wrr(asr_pkg::OFF_TX_STAT_CTRL, 8'h04);
      i_tx.send(9'h0a5, 8, 1'b1);
      chk("pend", pend, 1'b1);
      rdc(asr_pkg::OFF_PER_FLAG, 8'h20);
      wrr(asr_pkg::OFF_PER_ENABLE, 8'h20);
      chk("irq off", irq, 1'b0);
      wrr(asr_pkg::OFF_INT_CTRL, 8'hc0);
      chk("irq on", irq, 1'b1);
      i_tx.send(9'h03c, 8, 1'b0);
      i_tx.send(9'h0ff, 8, 1'b1);
      rdc(asr_pkg::OFF_RCV_STAT_CTRL, 8'h92);
      rdc(asr_pkg::OFF_RX_DATA, 8'ha5);
      rdc(asr_pkg::OFF_RCV_STAT_CTRL, 8'h96);
      rdc(asr_pkg::OFF_RX_DATA, 8'h3c);
      chk("pend empty", pend, 1'b0);
      rdc(asr_pkg::OFF_RX_DATA, 8'h00);
      i_tx.send(9'h011, 8, 1'b1);
      chk("blocked", pend, 1'b0);
      wrr(asr_pkg::OFF_RCV_STAT_CTRL, 8'h80);
      wrr(asr_pkg::OFF_RCV_STAT_CTRL, 8'h90);
      rdc(asr_pkg::OFF_RCV_STAT_CTRL, 8'h90);
      i_tx.send(9'h05a, 8, 1'b1);
      rdc(asr_pkg::OFF_RX_DATA, 8'h5a);
      i_tx.glitch();
      chk("false start", pend, 1'b0);
      rdc(asr_pkg::OFF_RCV_STAT_CTRL, 8'h90);
      i_tx.send(9'h0c3, 8, 1'b1);
      rdc(asr_pkg::OFF_RX_DATA, 8'hc3);
      i_tx.send(9'h066, 8, 1'b0);
      wrr(asr_pkg::OFF_RCV_STAT_CTRL, 8'h80);
      chk("pend off", pend, 1'b0);
      wrr(asr_pkg::OFF_RCV_STAT_CTRL, 8'h90);
      rdc(asr_pkg::OFF_RCV_STAT_CTRL, 8'h94);
      wrr(asr_pkg::OFF_RCV_STAT_CTRL, 8'h00);
      wrr(asr_pkg::OFF_RCV_STAT_CTRL, 8'h90);
      rdc(asr_pkg::OFF_RCV_STAT_CTRL, 8'h90);
      chk("port clr", pend, 1'b0);
      wrr(asr_pkg::OFF_RCV_STAT_CTRL, 8'hd8);
      i_tx.send(9'h055, 9, 1'b1);
      chk("addr drop", pend, 1'b0);
      i_tx.send(9'h1a7, 9, 1'b1);
      rdc(asr_pkg::OFF_RCV_STAT_CTRL, 8'hd9);
      rdc(asr_pkg::OFF_RX_DATA, 8'ha7);
      wrr(asr_pkg::OFF_RCV_STAT_CTRL, 8'hd0);
      i_tx.send(9'h033, 9, 1'b1);
      rdc(asr_pkg::OFF_RCV_STAT_CTRL, 8'hd0);
      rdc(asr_pkg::OFF_RX_DATA, 8'h33);
      wrap_up();
   end
endmodule
